// ### test/timer16_status_and_capture_regs_tb.sv
module timer16_status_and_capture_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // Bus lines; hsel, htrans, haddr, hwrite and hwdata driven by the transfer task
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    // Pins shared with the pin model, plus the interrupt
    logic cap1;
    logic cap2;
    logic cmp1;
    logic cmp2;
    logic timerIrq;
    // Last read word, saved counter bytes
    logic [31:0] rd;
    logic [31:0] cl;
    logic [31:0] ch;
    int mismatches = 0;
    int check_count = 0;

    always #12.5 clk_sys = ~clk_sys;

    tmr_timer16 u_tmr_timer16 (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .capture1Input(cap1),
        .capture2Input(cap2), .compare1Output(cmp1), .compare2Output(cmp2),
        .timerIrq(timerIrq));
    tmr_pin_model u_tmr_pin_model (.clk_sys(clk_sys), .compare1Output(cmp1),
        .compare2Output(cmp2), .capture1Input(cap1), .capture2Input(cap2));

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // One single transfer; never assumes how long the slave takes
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= tmr_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        xfer(1'b1, {24'h0, a}, wd);
    endtask

    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, {24'h0, a}, 32'h0);
        check(n, rd, e);
    endtask

    // Status read that looks only at the masked bits
    task automatic stat(input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, {24'h0, tmr_pkg::OFF_STATUS}, 32'h0);
        check("status", rd & m, e);
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        stat(32'hff, 32'h00);
        rdc("cap1 lo", tmr_pkg::OFF_CAP1_LO, 32'h0);
        // Compare values just ahead of a freshly cleared counter
        wr(tmr_pkg::OFF_CMP1_HI, 32'h0);
        wr(tmr_pkg::OFF_CMP1_LO, 32'h20);
        wr(tmr_pkg::OFF_CMP2_HI, 32'h0);
        wr(tmr_pkg::OFF_CMP2_LO, 32'h30);
        rdc("cmp1 lo", tmr_pkg::OFF_CMP1_LO, 32'h20);
        // Unmapped read right after a nonzero one, so stale data would show
        xfer(1'b0, 32'h100, 32'h0);
        check("unmapped", rd, 32'h0);
        wr(tmr_pkg::OFF_CONTROL, 32'hf0);
        wr(tmr_pkg::OFF_CNT_LO, 32'h0);
        rdc("cnt cleared", tmr_pkg::OFF_CNT_LO, 32'h0);
        repeat (40) @(posedge clk_sys);
        xfer(1'b0, {24'h0, tmr_pkg::OFF_CNT_LO}, 32'h0);
        check("cnt rate", rd >= 32'd10 && rd <= 32'd11, 32'h1);
        repeat (200) @(posedge clk_sys);
        stat(32'hff, 32'h48);
        check("out1 rises", u_tmr_pin_model.rises1, 32'h1);
        check("out2 rises", u_tmr_pin_model.rises2, 32'h1);
        rdc("cmp1 lo", tmr_pkg::OFF_CMP1_LO, 32'h20);
        stat(32'hff, 32'h08);
        wr(tmr_pkg::OFF_CMP2_LO, 32'h30);
        stat(32'hff, 32'h00);
        // Stopped clock keeps the counter still, so captures are exact
        wr(tmr_pkg::OFF_CONTROL, 32'h304);
        xfer(1'b0, {24'h0, tmr_pkg::OFF_CNT_LO}, 32'h0);
        cl = rd;
        xfer(1'b0, {24'h0, tmr_pkg::OFF_CNT_HI}, 32'h0);
        ch = rd;
        rdc("alt lo", tmr_pkg::OFF_ACNT_LO, cl);
        rdc("alt hi", tmr_pkg::OFF_ACNT_HI, ch);
        u_tmr_pin_model.strobe();
        repeat (10) @(posedge clk_sys);
        stat(32'hff, 32'h90);
        rdc("cap1 lo", tmr_pkg::OFF_CAP1_LO, cl);
        rdc("cap1 hi", tmr_pkg::OFF_CAP1_HI, ch);
        rdc("cap2 hi", tmr_pkg::OFF_CAP2_HI, ch);
        stat(32'hff, 32'h10);
        rdc("cap2 lo", tmr_pkg::OFF_CAP2_LO, cl);
        stat(32'hff, 32'h00);
        // Freeze, then show the registers still answer
        wr(tmr_pkg::OFF_CONTROL, 32'hf0);
        wr(tmr_pkg::OFF_STATUS, 32'h04);
        xfer(1'b0, {24'h0, tmr_pkg::OFF_CNT_LO}, 32'h0);
        cl = rd;
        repeat (40) @(posedge clk_sys);
        rdc("frozen cnt", tmr_pkg::OFF_CNT_LO, cl);
        check("frozen out1", cmp1, 32'h0);
        wr(tmr_pkg::OFF_ACNT_LO, 32'h0);
        rdc("frozen reset", tmr_pkg::OFF_CNT_LO, 32'h0);
        stat(32'hff, 32'h04);
        wr(tmr_pkg::OFF_STATUS, 32'h00);
        repeat (40) @(posedge clk_sys);
        xfer(1'b0, {24'h0, tmr_pkg::OFF_CNT_LO}, 32'h0);
        check("resumed", rd >= 32'd9 && rd <= 32'd12, 32'h1);
        // PWM mode: compare 2 ends the period and raises the capture 1 flag
        wr(tmr_pkg::OFF_CONTROL, 32'hf8);
        wr(tmr_pkg::OFF_CNT_LO, 32'h0);
        repeat (200) @(posedge clk_sys);
        stat(32'hf8, 32'hc8);
        xfer(1'b0, {24'h0, tmr_pkg::OFF_CNT_LO}, 32'h0);
        check("pwm reload", rd < 32'h20, 32'h1);
        check("pwm out1", u_tmr_pin_model.rises1, 32'h2);
        // Freeze must pull a high compare pin low
        wr(tmr_pkg::OFF_STATUS, 32'h04);
        repeat (2) @(posedge clk_sys);
        check("freeze out1", cmp1, 32'h0);
        wr(tmr_pkg::OFF_STATUS, 32'h00);
        // Fastest prescaler so a full wrap fits in the run
        wr(tmr_pkg::OFF_CONTROL, 32'h101);
        wr(tmr_pkg::OFF_CNT_LO, 32'h0);
        for (int i = 0; i < 140000 && timerIrq !== 1'b1; i++) @(posedge clk_sys);
        check("irq", timerIrq, 32'h1);
        stat(32'h20, 32'h20);
        xfer(1'b0, {24'h0, tmr_pkg::OFF_ACNT_LO}, 32'h0);
        check("alt lo", rd <= 32'h3, 32'h1);
        stat(32'h20, 32'h20);
        wr(tmr_pkg::OFF_CONTROL, 32'h100);
        repeat (3) @(posedge clk_sys);
        check("irq masked", timerIrq, 32'h0);
        wr(tmr_pkg::OFF_CONTROL, 32'h101);
        repeat (3) @(posedge clk_sys);
        check("irq again", timerIrq, 32'h1);
        stat(32'h20, 32'h20);
        xfer(1'b0, {24'h0, tmr_pkg::OFF_CNT_LO}, 32'h0);
        stat(32'h20, 32'h00);
        repeat (3) @(posedge clk_sys);
        check("irq gone", timerIrq, 32'h0);
        wrap_up();
    end

    // Run needs about 135000 clocks; give it half as much again
    initial
    begin
        #5000000;
        mismatches++;
        wrap_up();
    end
endmodule

// ### test/tmr_pin_model.sv
module tmr_pin_model (
    input wire logic clk_sys,
    input wire logic compare1Output,
    input wire logic compare2Output,
    output logic capture1Input,
    output logic capture2Input
);
    timeunit 1ns;
    timeprecision 1ps;
    // Rising edges seen on each compare pin
    int rises1 = 0;
    int rises2 = 0;

    // Pin 1 idles high and pin 2 low, so a strobe gives opposite edges
    initial
    begin
        capture1Input = 1'b1;
        capture2Input = 1'b0;
    end

    always @(posedge compare1Output) rises1++;
    always @(posedge compare2Output) rises2++;

    // Pulse held for four clocks, well past the input synchroniser
    task automatic strobe();
        capture1Input <= 1'b0;
        capture2Input <= 1'b1;
        repeat (4) @(posedge clk_sys);
        capture1Input <= 1'b1;
        capture2Input <= 1'b0;
    endtask
endmodule

// ### test/tmr_timer16_sva.sv
module tmr_timer16_sva (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic capture1Input,
    input wire logic capture2Input,
    input wire logic compare1Output,
    input wire logic compare2Output,
    input wire logic timerIrq
);
    timeunit 1ns;
    timeprecision 1ps;
    // Address phase accepted in this cycle
    logic addrPh;
    // Kind and offset of the transfer now in its data phase
    logic rdQ;
    logic wrQ;
    logic lowQ;
    logic [7:0] offQ;
    // Overflow interrupt enable, learnt from control writes
    logic ieQ;
    // Status word is on hrdata this cycle
    logic stData;
    assign addrPh = hsel && hready && htrans == tmr_pkg::HTRANS_NONSEQ;
    assign stData = rdQ && lowQ && offQ == tmr_pkg::OFF_STATUS;

    // Zero wait slave, so the data phase is always the next cycle
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rdQ <= 1'b0;
            wrQ <= 1'b0;
            lowQ <= 1'b0;
            offQ <= 8'h00;
        end
        else
        begin
            rdQ <= addrPh && !hwrite;
            wrQ <= addrPh && hwrite;
            lowQ <= haddr[31:8] == 24'h000000;
            offQ <= haddr[7:0];
        end
    end

    // Write data lands at the end of the data phase, as in the design
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            ieQ <= 1'b0;
        else if (wrQ && lowQ && offQ == tmr_pkg::OFF_CONTROL)
            ieQ <= hwdata[tmr_pkg::CT_OVF_IE];
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    chk_ready_high: assert property (hreadyout)
        else $error("hreadyout low outside reset");
    chk_resp_okay: assert property (!hresp)
        else $error("hresp not OKAY");
    chk_reserved_bits: assert property (
        stData |-> hrdata[1:0] == 2'h0 && hrdata[31:8] == 24'h0)
        else $error("status reserved bits not zero");
    chk_byte_upper: assert property (
        rdQ && lowQ && offQ < tmr_pkg::OFF_CONTROL |-> hrdata[31:8] == 24'h0)
        else $error("byte register upper bits not zero");
    chk_frozen_pins: assert property (
        stData && hrdata[tmr_pkg::ST_FREEZE] |-> !compare1Output && !compare2Output)
        else $error("compare pin driven while frozen");
    chk_irq_follow: assert property (
        stData && hrdata[tmr_pkg::ST_OVF] && ieQ |-> ##[0:2] timerIrq)
        else $error("overflow set and enabled but no interrupt");
    chk_alt_keeps: assert property (
        addrPh && haddr == {24'h0, tmr_pkg::OFF_ACNT_LO} && timerIrq && ieQ
        |-> ##1 timerIrq [*3])
        else $error("alternate counter access dropped the overflow");
    chk_ovf_clears: assert property (
        timerIrq && addrPh && !hwrite && haddr == {24'h0, tmr_pkg::OFF_STATUS}
        ##2 addrPh && haddr == {24'h0, tmr_pkg::OFF_CNT_LO} |-> ##[1:3] !timerIrq)
        else $error("overflow not cleared by counter low access");

    cover property (stData && hrdata[tmr_pkg::ST_OVF]);
    cover property (stData && hrdata[tmr_pkg::ST_FREEZE]);
    cover property (stData && hrdata[tmr_pkg::ST_CAP1] && hrdata[tmr_pkg::ST_CAP2]);
endmodule

bind tmr_timer16 tmr_timer16_sva u_tmr_timer16_sva (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .capture1Input(capture1Input),
    .capture2Input(capture2Input), .compare1Output(compare1Output),
    .compare2Output(compare2Output), .timerIrq(timerIrq)
);

// ### verilog/tmr_pkg.sv
package tmr_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CAP1_HI = 8'h04;
    localparam logic [7:0] OFF_CAP1_LO = 8'h08;
    localparam logic [7:0] OFF_CMP1_HI = 8'h0c;
    localparam logic [7:0] OFF_CMP1_LO = 8'h10;
    localparam logic [7:0] OFF_CMP2_HI = 8'h14;
    localparam logic [7:0] OFF_CMP2_LO = 8'h18;
    localparam logic [7:0] OFF_CNT_HI = 8'h1c;
    localparam logic [7:0] OFF_CNT_LO = 8'h20;
    localparam logic [7:0] OFF_ACNT_HI = 8'h24;
    localparam logic [7:0] OFF_ACNT_LO = 8'h28;
    localparam logic [7:0] OFF_CAP2_HI = 8'h2c;
    localparam logic [7:0] OFF_CAP2_LO = 8'h30;
    localparam logic [7:0] OFF_CONTROL = 8'h34;

    // Status register field positions
    localparam int unsigned ST_CAP1 = 7;
    localparam int unsigned ST_CMP1 = 6;
    localparam int unsigned ST_OVF = 5;
    localparam int unsigned ST_CAP2 = 4;
    localparam int unsigned ST_CMP2 = 3;
    localparam int unsigned ST_FREEZE = 2;

    // Index of each flag inside the internal five-bit flag vector
    localparam int unsigned FL_CAP1 = 4;
    localparam int unsigned FL_CMP1 = 3;
    localparam int unsigned FL_OVF = 2;
    localparam int unsigned FL_CAP2 = 1;
    localparam int unsigned FL_CMP2 = 0;

    // Control register field positions
    localparam int unsigned CT_OVF_IE = 0;
    localparam int unsigned CT_EDGE1 = 1;
    localparam int unsigned CT_EDGE2 = 2;
    localparam int unsigned CT_PWM = 3;
    localparam int unsigned CT_OUT1_EN = 4;
    localparam int unsigned CT_OUT2_EN = 5;
    localparam int unsigned CT_LEVEL1 = 6;
    localparam int unsigned CT_LEVEL2 = 7;
    localparam int unsigned CT_CLKSEL = 8;
    localparam logic [9:0] CONTROL_WMASK = 10'h3ff;

    // Reset values
    localparam logic [9:0] CONTROL_RESET = 10'h000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;

    // Prescaler clock selections and their divide ratios
    localparam logic [1:0] CLK_DIV4 = 2'h0;
    localparam logic [1:0] CLK_DIV2 = 2'h1;
    localparam logic [1:0] CLK_DIV8 = 2'h2;
    localparam logic [1:0] CLK_STOP = 2'h3;
    localparam logic [2:0] DIV4_LAST = 3'h3;
    localparam logic [2:0] DIV2_LAST = 3'h1;
    localparam logic [2:0] DIV8_LAST = 3'h7;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

endpackage

// ### verilog/tmr_timer16.sv
// Function
// - Capture or PWM period match sets capture1 flag
// - Status read then capture1 low clears flag
// - Counter equal compare1 sets compare1 flag
// - Status read then compare1 low clears flag
// - Counter wrap from max sets overflow flag
// - Status read then counter low clears overflow
// - Alternate counter low never clears overflow
// - Active capture2 edge sets capture2 flag
// - Status read then capture2 low clears flag
// - Counter equal compare2 sets compare2 flag
// - Status read then compare2 low clears flag
// - All flags reset to zero
// - Freeze halts prescaler, counter, compare outputs
// - Registers stay accessible while frozen
// - Capture1 event loads counter into capture1 pair
// - Capture2 event loads counter into capture2 pair
// - Compare values held as byte pairs, compared
// - Counter readable through primary and alternate pairs
// - Write to either counter low resets counter
// - Overflow flag with enable raises interrupt request
module tmr_timer16 (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic capture1Input,
    input wire logic capture2Input,
    output logic compare1Output,
    output logic compare2Output,
    output logic timerIrq
);

    // Bus-side state
    logic wrPend_q; // Write data phase pending
    logic [7:0] wrAddr_q; // Offset of pending write
    logic [31:0] rdata_q; // Read data for the data phase
    logic hresp_q; // Always OKAY

    // Timer state
    logic [15:0] count_q; // Free-running counter
    logic [2:0] presc_q; // Prescaler phase
    logic [15:0] cmp1_q; // Compare 1 value
    logic [15:0] cmp2_q; // Compare 2 value
    logic [15:0] cap1_q; // Capture 1 value
    logic [15:0] cap2_q; // Capture 2 value
    logic [4:0] flags_q; // Event flags
    logic [4:0] armed_q; // Flags seen by a status read
    logic freeze_q; // Timer frozen
    logic [9:0] ctrl_q; // Control register
    logic out1_q; // Compare 1 pin level
    logic out2_q; // Compare 2 pin level
    logic irq_q; // Interrupt request

    // Capture input synchronisers and edge history
    logic cap1Meta_q, cap1Sync_q, cap1Prev_q;
    logic cap2Meta_q, cap2Sync_q, cap2Prev_q;

    // Decoded access strobes
    logic addrPhase; // Accepted transfer this cycle
    logic mapped; // Upper address bits are zero
    logic rdStrobe; // Read taken this cycle
    logic [7:0] offset; // Byte offset of the request
    logic wrStrobe; // Write data present this cycle
    logic [4:0] flagSet; // Flag set events
    logic [4:0] flagClr; // Flag clear accesses
    logic tick; // Prescaled counter step
    logic [2:0] prescLast; // Last prescaler phase
    logic [15:0] countNext; // Counter after a step
    logic cntWrite; // Counter reset by software
    logic match1; // Counter reaches compare 1
    logic match2; // Counter reaches compare 2
    logic cap1Evt; // Active edge on capture 1
    logic cap2Evt; // Active edge on capture 2
    logic pwmReload; // Period end in PWM mode
    logic [31:0] rdMux; // Read data selected by offset

    // Address phase decode; hsize is ignored since only word transfers are used
    always_comb
    begin
        addrPhase = hsel && hready && (htrans == tmr_pkg::HTRANS_NONSEQ);
        mapped = (haddr[31:8] == 24'h000000);
        offset = haddr[7:0];
        rdStrobe = addrPhase && !hwrite && mapped;
        wrStrobe = wrPend_q;
    end

    // Write data phase capture; unmapped writes are dropped here
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
        end
        else
        begin
            wrPend_q <= addrPhase && hwrite && mapped;
            wrAddr_q <= offset;
        end
    end

    // Read data source per offset; holes read as zero
    always_comb
    begin
        rdMux = 32'h00000000;
        unique case (offset)
            tmr_pkg::OFF_STATUS: rdMux[7:0] = {flags_q, freeze_q, 2'b00};
            tmr_pkg::OFF_CAP1_HI: rdMux[7:0] = cap1_q[15:8];
            tmr_pkg::OFF_CAP1_LO: rdMux[7:0] = cap1_q[7:0];
            tmr_pkg::OFF_CMP1_HI: rdMux[7:0] = cmp1_q[15:8];
            tmr_pkg::OFF_CMP1_LO: rdMux[7:0] = cmp1_q[7:0];
            tmr_pkg::OFF_CMP2_HI: rdMux[7:0] = cmp2_q[15:8];
            tmr_pkg::OFF_CMP2_LO: rdMux[7:0] = cmp2_q[7:0];
            tmr_pkg::OFF_CNT_HI, tmr_pkg::OFF_ACNT_HI: rdMux[7:0] = count_q[15:8];
            tmr_pkg::OFF_CNT_LO, tmr_pkg::OFF_ACNT_LO: rdMux[7:0] = count_q[7:0];
            tmr_pkg::OFF_CAP2_HI: rdMux[7:0] = cap2_q[15:8];
            tmr_pkg::OFF_CAP2_LO: rdMux[7:0] = cap2_q[7:0];
            tmr_pkg::OFF_CONTROL: rdMux[9:0] = ctrl_q;
            default: rdMux = 32'h00000000;
        endcase
    end

    // Zero-wait slave: data is registered in the address phase and stands in the data phase
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rdata_q <= 32'h00000000;
            hresp_q <= tmr_pkg::HRESP_OKAY;
        end
        else
        begin
            // Unmapped reads return zero rather than stale data
            if (addrPhase && !hwrite)
                rdata_q <= mapped ? rdMux : 32'h00000000;
            hresp_q <= tmr_pkg::HRESP_OKAY;
        end
    end

    // Status and control writes; freeze stays writable at all times
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            freeze_q <= 1'b0;
            ctrl_q <= tmr_pkg::CONTROL_RESET;
        end
        else if (wrStrobe)
        begin
            if (wrAddr_q == tmr_pkg::OFF_STATUS)
            begin
                // Flags and reserved bits are not writable
                freeze_q <= hwdata[tmr_pkg::ST_FREEZE];
            end
            if (wrAddr_q == tmr_pkg::OFF_CONTROL)
            begin
                ctrl_q <= hwdata[9:0] & tmr_pkg::CONTROL_WMASK;
            end
        end
    end

    // Compare value bytes, accepted even while frozen
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cmp1_q <= tmr_pkg::COUNT_MAX;
            cmp2_q <= tmr_pkg::COUNT_MAX;
        end
        else if (wrStrobe)
        begin
            unique case (wrAddr_q)
                tmr_pkg::OFF_CMP1_HI: cmp1_q[15:8] <= hwdata[7:0];
                tmr_pkg::OFF_CMP1_LO: cmp1_q[7:0] <= hwdata[7:0];
                tmr_pkg::OFF_CMP2_HI: cmp2_q[15:8] <= hwdata[7:0];
                tmr_pkg::OFF_CMP2_LO: cmp2_q[7:0] <= hwdata[7:0];
                default: cmp1_q <= cmp1_q;
            endcase
        end
    end

    // Prescaler limit; the external clock choice has no pin here and stops the counter
    always_comb
    begin
        prescLast = tmr_pkg::DIV4_LAST;
        unique case (ctrl_q[tmr_pkg::CT_CLKSEL +: 2])
            tmr_pkg::CLK_DIV4: prescLast = tmr_pkg::DIV4_LAST;
            tmr_pkg::CLK_DIV2: prescLast = tmr_pkg::DIV2_LAST;
            tmr_pkg::CLK_DIV8: prescLast = tmr_pkg::DIV8_LAST;
            tmr_pkg::CLK_STOP: prescLast = tmr_pkg::DIV8_LAST;
        endcase
        tick = !freeze_q && (ctrl_q[tmr_pkg::CT_CLKSEL +: 2] != tmr_pkg::CLK_STOP)
            && (presc_q == prescLast);
        countNext = count_q + 16'h0001;
        cntWrite = wrStrobe && ((wrAddr_q == tmr_pkg::OFF_CNT_LO)
            || (wrAddr_q == tmr_pkg::OFF_ACNT_LO));
        // Matches fire once, on the step that lands on the value
        match1 = tick && (countNext == cmp1_q);
        match2 = tick && (countNext == cmp2_q);
        pwmReload = match2 && ctrl_q[tmr_pkg::CT_PWM];
    end

    // Prescaler phase; held while frozen so the phase resumes where it stopped
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            presc_q <= 3'h0;
        else if (cntWrite)
            presc_q <= 3'h0;
        else if (!freeze_q)
            presc_q <= (presc_q >= prescLast) ? 3'h0 : presc_q + 3'h1;
    end

    // Free-running counter; a software reset wins over a step
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            count_q <= tmr_pkg::COUNT_RESET;
        else if (cntWrite)
            count_q <= tmr_pkg::COUNT_RESET;
        else if (pwmReload) // PWM period ends at the compare 2 value
            count_q <= tmr_pkg::COUNT_RESET;
        else if (tick)
            count_q <= countNext;
    end

    // Two-flop synchronisers, then a third stage as edge history
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cap1Meta_q <= 1'b0;
            cap1Sync_q <= 1'b0;
            cap1Prev_q <= 1'b0;
            cap2Meta_q <= 1'b0;
            cap2Sync_q <= 1'b0;
            cap2Prev_q <= 1'b0;
        end
        else
        begin
            cap1Meta_q <= capture1Input;
            cap1Sync_q <= cap1Meta_q;
            cap1Prev_q <= cap1Sync_q;
            cap2Meta_q <= capture2Input;
            cap2Sync_q <= cap2Meta_q;
            cap2Prev_q <= cap2Sync_q;
        end
    end

    // Active edge per selected polarity; captures keep working while frozen
    always_comb
    begin
        cap1Evt = ctrl_q[tmr_pkg::CT_EDGE1] ? (cap1Sync_q && !cap1Prev_q)
            : (!cap1Sync_q && cap1Prev_q);
        cap2Evt = ctrl_q[tmr_pkg::CT_EDGE2] ? (cap2Sync_q && !cap2Prev_q)
            : (!cap2Sync_q && cap2Prev_q);
    end

    // Capture registers load the live counter
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cap1_q <= 16'h0000;
            cap2_q <= 16'h0000;
        end
        else
        begin
            if (cap1Evt)
                cap1_q <= count_q;
            if (cap2Evt)
                cap2_q <= count_q;
        end
    end

    // Flag set and clear terms; a clear needs an earlier status read that saw the flag
    always_comb
    begin
        flagSet = 5'h00;
        flagSet[tmr_pkg::FL_CAP1] = cap1Evt || pwmReload;
        flagSet[tmr_pkg::FL_CMP1] = match1;
        flagSet[tmr_pkg::FL_OVF] = tick && !pwmReload && (count_q == tmr_pkg::COUNT_MAX);
        flagSet[tmr_pkg::FL_CAP2] = cap2Evt;
        flagSet[tmr_pkg::FL_CMP2] = match2;
        // Reads clear in the address phase, writes in the data phase
        flagClr = 5'h00;
        flagClr[tmr_pkg::FL_CAP1] = (rdStrobe && offset == tmr_pkg::OFF_CAP1_LO)
            || (wrStrobe && wrAddr_q == tmr_pkg::OFF_CAP1_LO);
        flagClr[tmr_pkg::FL_CMP1] = (rdStrobe && offset == tmr_pkg::OFF_CMP1_LO)
            || (wrStrobe && wrAddr_q == tmr_pkg::OFF_CMP1_LO);
        // Only the primary counter low clears overflow, never the alternate
        flagClr[tmr_pkg::FL_OVF] = (rdStrobe && offset == tmr_pkg::OFF_CNT_LO)
            || (wrStrobe && wrAddr_q == tmr_pkg::OFF_CNT_LO);
        flagClr[tmr_pkg::FL_CAP2] = (rdStrobe && offset == tmr_pkg::OFF_CAP2_LO)
            || (wrStrobe && wrAddr_q == tmr_pkg::OFF_CAP2_LO);
        flagClr[tmr_pkg::FL_CMP2] = (rdStrobe && offset == tmr_pkg::OFF_CMP2_LO)
            || (wrStrobe && wrAddr_q == tmr_pkg::OFF_CMP2_LO);
        flagClr = flagClr & armed_q;
    end

    // Sticky flags; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            flags_q <= 5'h00;
        end
        else
        begin
            flags_q <= (flags_q & ~flagClr) | flagSet;
        end
    end

    // Arming: a status read remembers which flags it showed, so an unseen event survives
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            armed_q <= 5'h00;
        end
        else if (rdStrobe && offset == tmr_pkg::OFF_STATUS)
        begin
            armed_q <= flags_q;
        end
        else
        begin
            armed_q <= armed_q & ~flagClr;
        end
    end

    // Compare pin levels; in PWM mode pin 1 carries both levels, pin 2 is idle
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            out1_q <= 1'b0;
            out2_q <= 1'b0;
        end
        else if (freeze_q || !ctrl_q[tmr_pkg::CT_OUT1_EN])
        begin
            out1_q <= 1'b0;
            out2_q <= ctrl_q[tmr_pkg::CT_OUT2_EN] && !freeze_q ? out2_q : 1'b0;
        end
        else
        begin
            if (ctrl_q[tmr_pkg::CT_PWM])
            begin
                if (match1)
                    out1_q <= ctrl_q[tmr_pkg::CT_LEVEL2];
                else if (pwmReload)
                    out1_q <= ctrl_q[tmr_pkg::CT_LEVEL1];
            end
            else if (match1)
                out1_q <= ctrl_q[tmr_pkg::CT_LEVEL1];
            if (!ctrl_q[tmr_pkg::CT_OUT2_EN] || ctrl_q[tmr_pkg::CT_PWM])
                out2_q <= 1'b0;
            else if (match2)
                out2_q <= ctrl_q[tmr_pkg::CT_LEVEL2];
        end
    end

    // Interrupt request follows the overflow flag when enabled
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= flags_q[tmr_pkg::FL_OVF] && ctrl_q[tmr_pkg::CT_OVF_IE];
        end
    end

    // Output drive from flip-flops, hreadyout from rst; the slave never inserts wait states
    always_comb
    begin
        hrdata = rdata_q;
        hresp = hresp_q;
        hreadyout = !rst;
        compare1Output = out1_q;
        compare2Output = out2_q;
        timerIrq = irq_q;
    end

endmodule
